//--- design/csc_edge_sel.sv
// Purpose: Synchronise sensor inputs and turn selected edges into count steps
// Assumes: Sensor inputs asynchronous to ref_clk_i
// Notes:   One step pulse per counted edge, with direction
`timescale 1ns/1ps
`default_nettype none

module csc_edge_sel
	import csc_pkg::*;
(
	// Clock and reset
	input  wire logic      ref_clk_i,
	input  wire logic      reset_i,
	input  wire logic      ce_i,
	// Configuration
	input  wire csc_mode_t mode_i,
	// Sensor pins
	input  wire logic      sig_a_i,
	input  wire logic      sig_b_i,
	// Count steps
	output logic           step_o,
	output logic           down_o
);

	// ----------------------------------------------------------------
	// Synchronisers and history
	// ----------------------------------------------------------------
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
			prev_q <= 2'h0;
		end else if (ce_i) begin
			meta_q <= {sig_b_i, sig_a_i};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// ----------------------------------------------------------------
	// Edge selection
	// ----------------------------------------------------------------
	wire a_rise  = sync_q[0] & ~prev_q[0];
	wire a_chg   = sync_q[0] ^ prev_q[0];
	wire b_chg   = sync_q[1] ^ prev_q[1];
	wire q_valid = a_chg ^ b_chg;
	wire q_down  = ~(sync_q[0] ^ prev_q[1]);
	wire step_d  = (mode_i == CSC_MODE_ONE) ? a_rise :
	               (mode_i == CSC_MODE_TWO) ? a_chg  : q_valid;
	wire down_d  = (mode_i == CSC_MODE_QUAD) & q_valid & q_down;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			step_o <= 1'b0;
			down_o <= 1'b0;
		end else if (ce_i) begin
			step_o <= step_d;
			down_o <= down_d;
		end
	end

endmodule : csc_edge_sel

`default_nettype wire

//--- design/csc_pkg.sv
// Purpose: Types shared by the count input scaler
// Assumes: csc_regs.svh on the include path
// Notes:   Constants live in the header
`include "csc_regs.svh"

package csc_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CSC_MODE_ONE,
		CSC_MODE_TWO,
		CSC_MODE_QUAD
	} csc_mode_t;

	typedef struct packed {
		logic [2:0] scale_multiplier;
		logic [1:0] edge_sel;
		logic [2:0] resp;
	} csc_ctrl_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [3:0] addr;
		logic [31:0] wdata;
	} csc_bus_req_t;

	typedef struct packed {
		logic signed [3:0] delta;
		logic [26:0]       frac;
	} csc_step_t;

endpackage : csc_pkg

//--- design/csc_regs.svh
// Purpose: Register offsets, field positions, reset values and scaling constants
// Assumes: Included by the scaler package and the scaler module
// Notes:   Definitions only
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CSC_ADDR_W          4
`define CSC_ADDR_CTRL       4'h0
`define CSC_ADDR_SCALE      4'h1
`define CSC_ADDR_COUNT      4'h2
`define CSC_ADDR_REMAIN     4'h3
`define CSC_ADDR_CMD        4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CSC_RESP_LSB        0
`define CSC_RESP_MSB        2
`define CSC_EDGE_LSB        4
`define CSC_EDGE_MSB        5
`define CSC_SCM_LSB         8
`define CSC_SCM_MSB         10
`define CSC_CMD_DEFAULTS    0
`define CSC_CMD_CLEAR       1

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define CSC_RESP_NORMAL     3'h0
`define CSC_RESP_QUADRATURE_TIMES_FOUR    3'h6
`define CSC_EDGE_ONE        2'h1
`define CSC_EDGE_TWO        2'h2
`define CSC_SCM_X1          3'h1
`define CSC_SCM_X0_1        3'h2
`define CSC_SCM_X0_01       3'h3
`define CSC_SCM_X0_001      3'h4
`define CSC_SF_RESET        16'h2710
`define CSC_SF_MAX          16'hEA5F

// ----------------------------------------------------------------
// Fixed point: one display unit is 10^7 internal steps
// ----------------------------------------------------------------
`define CSC_UNIT            27'h098_9680
`define CSC_UNIT_X6         27'h393_8700
`define CSC_WEIGHT_X1       10'h3E8
`define CSC_WEIGHT_X0_1     10'h064
`define CSC_WEIGHT_X0_01    10'h00A
`define CSC_WEIGHT_X0_001   10'h001

`endif

//--- design/csc_scaler.sv
// Purpose: Scale counted sensor edges into an accumulated display count
// Assumes: Register port on ref_clk_i; sensor pins asynchronous
// Notes:   Fraction kept internally in steps of 10^-7 display unit
//
// Functional notes
// - Total scaling per input pulse is scale factor times multiplier times edges per pulse.
// - Edges per pulse may be one, two or four, four only in quadrature counting.
// - Edge selection mode 2 counts both the rising and falling edge of each pulse.
// - Input response mode 6 selects quadrature times four counting.
// - A factory default load sets one counted edge per pulse.
// - A factory default load sets the scale multiplier to one.
// - Each counted edge advances the display by its scaled share, which can jump the display by up to 6 counts at once.
// - The scale factor holds four fractional digits up to 5.9999.
// - The multiplier offers one tenth and one hundredth settings.
// - Multiplier modes 1 to 4 select times one, tenth, hundredth and thousandth.
// - Quadrature mode counts every edge of both inputs, except edges on both inputs in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "csc_regs.svh"

module csc_scaler
	import csc_pkg::*;
#(
	parameter int COUNT_W = 32
) (
	// Clock and reset
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   ce_i,
	// Register port
	input  wire logic [`CSC_ADDR_W-1:0] addr_i,
	input  wire logic [31:0]            wdata_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output logic [31:0]                 rdata_o,
	// Sensor pins
	input  wire logic                   sig_a_i,
	input  wire logic                   sig_b_i,
	// Display count
	output logic signed [COUNT_W-1:0]   display_count_o
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_width
		$error("csc_scaler: COUNT_W must be 8 to 32");
	end

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [9:0] scm_weight(input logic [2:0] scale_multiplier);
		logic [9:0] w;
		w = `CSC_WEIGHT_X1;
		unique case (scale_multiplier)
			`CSC_SCM_X0_1:   w = `CSC_WEIGHT_X0_1;
			`CSC_SCM_X0_01:  w = `CSC_WEIGHT_X0_01;
			`CSC_SCM_X0_001: w = `CSC_WEIGHT_X0_001;
			default:         w = `CSC_WEIGHT_X1;
		endcase
		return w;
	endfunction : scm_weight

	function automatic csc_step_t accumulate(
		input logic [26:0] frac,
		input logic [26:0] inc,
		input logic        down
	);
		csc_step_t  r;
		logic [26:0] s;
		logic [3:0]  whole;
		s     = down ? (frac + `CSC_UNIT_X6 - inc) : (frac + inc);
		whole = 4'h0;
		for (int i = 0; i < 7; i++) begin
			if (s >= `CSC_UNIT) begin
				s     = s - `CSC_UNIT;
				whole = whole + 4'h1;
			end
		end
		r.frac  = s;
		r.delta = down ? $signed(whole - 4'h6) : $signed(whole);
		return r;
	endfunction : accumulate

	function automatic logic legal_scm(input logic [2:0] scale_multiplier);
		return (scale_multiplier >= `CSC_SCM_X1) && (scale_multiplier <= `CSC_SCM_X0_001);
	endfunction : legal_scm

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	csc_ctrl_t                 ctrl_q;
	logic [15:0]               sf_q;
	logic signed [COUNT_W-1:0] count_q;
	logic [26:0]               frac_q;
	logic [31:0]               rdata_q;

	csc_bus_req_t req;
	assign req = '{rd: rd_i, wr: wr_i, addr: addr_i, wdata: wdata_i};

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	wire        wr_ctrl   = req.wr && (req.addr == `CSC_ADDR_CTRL);
	wire        wr_scale  = req.wr && (req.addr == `CSC_ADDR_SCALE);
	wire        wr_cmd    = req.wr && (req.addr == `CSC_ADDR_CMD);
	wire        load_dflt = wr_cmd && req.wdata[`CSC_CMD_DEFAULTS];
	wire        clr_count = wr_cmd && req.wdata[`CSC_CMD_CLEAR];
	wire [2:0]  w_resp    = req.wdata[`CSC_RESP_MSB:`CSC_RESP_LSB];
	wire [1:0]  w_edge    = req.wdata[`CSC_EDGE_MSB:`CSC_EDGE_LSB];
	wire [2:0]  w_scm     = req.wdata[`CSC_SCM_MSB:`CSC_SCM_LSB];
	wire        w_edge_ok = (w_edge == `CSC_EDGE_ONE) || (w_edge == `CSC_EDGE_TWO);
	wire        w_scm_ok  = legal_scm(w_scm);
	wire [15:0] w_sf      = req.wdata[15:0];
	wire        w_sf_ok   = (req.wdata[31:16] == 16'h0000) && (w_sf <= `CSC_SF_MAX);

	// ----------------------------------------------------------------
	// Write qualification
	// ----------------------------------------------------------------
	wire ctrl_ok = wr_ctrl && w_edge_ok && w_scm_ok;

	csc_ctrl_t dflt_ctrl;
	assign dflt_ctrl = '{scale_multiplier: `CSC_SCM_X1, edge_sel: `CSC_EDGE_ONE, resp: `CSC_RESP_NORMAL};

	csc_ctrl_t w_ctrl;
	assign w_ctrl = '{scale_multiplier: w_scm, edge_sel: w_edge, resp: w_resp};

	csc_ctrl_t ctrl_d;
	assign ctrl_d = load_dflt ? dflt_ctrl :
	                ctrl_ok ? w_ctrl : ctrl_q;

	wire [15:0] sf_d = load_dflt ? `CSC_SF_RESET :
	                   (wr_scale && w_sf_ok) ? w_sf : sf_q;

	// ----------------------------------------------------------------
	// Edge mode selection
	// ----------------------------------------------------------------
	csc_mode_t mode;
	assign mode = (ctrl_q.resp == `CSC_RESP_QUADRATURE_TIMES_FOUR) ? CSC_MODE_QUAD :
	              (ctrl_q.edge_sel == `CSC_EDGE_TWO) ? CSC_MODE_TWO : CSC_MODE_ONE;

	logic step;
	logic down;

	csc_edge_sel u_edge_sel (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.ce_i      (ce_i),
		.mode_i    (mode),
		.sig_a_i   (sig_a_i),
		.sig_b_i   (sig_b_i),
		.step_o    (step),
		.down_o    (down)
	);

	// ----------------------------------------------------------------
	// Scaling arithmetic
	// ----------------------------------------------------------------
	wire [25:0] inc_raw = 26'(sf_q) * 26'(scm_weight(ctrl_q.scale_multiplier));
	wire [26:0] inc     = {1'b0, inc_raw};

	csc_step_t acc;
	assign acc = accumulate(frac_q, inc, down);

	wire signed [COUNT_W-1:0] delta_ext = COUNT_W'(acc.delta);
	wire signed [COUNT_W-1:0] count_d   = clr_count ? '0 :
	                                      step ? (count_q + delta_ext) : count_q;
	wire [26:0]               frac_d    = clr_count ? 27'h000_0000 :
	                                      step ? acc.frac : frac_q;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	wire [31:0] ctrl_rd  = {21'h00_0000, ctrl_q.scale_multiplier, 2'h0, ctrl_q.edge_sel, 1'b0, ctrl_q.resp};
	wire [31:0] count_rd = 32'(count_q);
	wire [31:0] rd_mux   = (req.addr == `CSC_ADDR_CTRL)   ? ctrl_rd :
	                       (req.addr == `CSC_ADDR_SCALE)  ? {16'h0000, sf_q} :
	                       (req.addr == `CSC_ADDR_COUNT)  ? count_rd :
	                       (req.addr == `CSC_ADDR_REMAIN) ? {5'h00, frac_q} :
	                       32'h0000_0000;
	wire [31:0] rdata_d  = req.rd ? rd_mux : 32'h0000_0000;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q <= '{scale_multiplier: `CSC_SCM_X1, edge_sel: `CSC_EDGE_ONE, resp: `CSC_RESP_NORMAL};
			sf_q   <= `CSC_SF_RESET;
		end else if (ce_i) begin
			ctrl_q <= ctrl_d;
			sf_q   <= sf_d;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			count_q <= '0;
			frac_q  <= 27'h000_0000;
		end else if (ce_i) begin
			count_q <= count_d;
			frac_q  <= frac_d;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_i) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_o         = rdata_q;
	assign display_count_o = count_q;

endmodule : csc_scaler

`default_nettype wire

//--- tb/csc_scaler_props.sv
// Purpose: Port-level properties of the count input scaler
// Assumes: ce_i high while checked
// Notes:   Bound to csc_scaler
`timescale 1ns/1ps
`default_nettype none

module csc_scaler_props #(
	parameter int COUNT_W = 32
) (
	// Clock and reset
	input wire logic                      ref_clk_i,
	input wire logic                      reset_i,
	input wire logic                      ce_i,
	// Register port
	input wire logic [3:0]                addr_i,
	input wire logic [31:0]               wdata_i,
	input wire logic                      wr_i,
	input wire logic                      rd_i,
	input wire logic [31:0]               rdata_o,
	// Sensor and count
	input wire logic                      sig_a_i,
	input wire logic                      sig_b_i,
	input wire logic signed [COUNT_W-1:0] display_count_o
);
	// ----------------------------------------------------------------
	// Helpers and properties
	// ----------------------------------------------------------------
	logic                      a_q;
	logic                      b_q;
	logic [7:0]                act_q;
	logic signed [COUNT_W-1:0] prev_q;
	wire signed [COUNT_W:0]    dlt = display_count_o - prev_q;

	always_ff @(posedge ref_clk_i) begin
		a_q    <= sig_a_i;
		b_q    <= sig_b_i;
		prev_q <= display_count_o;
		act_q  <= reset_i ? 8'h00 : {act_q[6:0], (a_q ^ sig_a_i) | (b_q ^ sig_b_i)};
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i || !ce_i);

	chk_count_reset: assert property ($fell(reset_i) |-> display_count_o == 0)
		else $error("count not zero after reset");
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
		else $error("read data not zero outside read");
	chk_unmapped_zero: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_count_read: assert property (rd_i && addr_i == 4'h2 |=>
		$signed(rdata_o) == $past(display_count_o))
		else $error("count read differs from port");
	chk_scale_back: assert property (wr_i && addr_i == 4'h1 && wdata_i < 32'd60000
		##2 rd_i && addr_i == 4'h1 |=> rdata_o == $past(wdata_i, 3))
		else $error("scale readback wrong");
	chk_defaults_load: assert property (wr_i && addr_i == 4'h4 && wdata_i[0]
		##2 rd_i && addr_i == 4'h0 |=> rdata_o[10:4] == 7'h11)
		else $error("defaults not loaded");
	chk_clear_count: assert property (wr_i && addr_i == 4'h4 && wdata_i[1] |=>
		display_count_o == 0)
		else $error("clear did not zero count");
	chk_step_bound: assert property (!$past(wr_i) |-> dlt <= 6 && dlt >= -6)
		else $error("count jumped too far");
	chk_count_cause: assert property ($changed(display_count_o) |->
		$past(wr_i) || act_q != 8'h00)
		else $error("count moved without cause");

	cover property (rd_i && addr_i == 4'h2);
	cover property (dlt < 0);
	cover property (wr_i && addr_i == 4'h4 && wdata_i[1]);
endmodule : csc_scaler_props

bind csc_scaler csc_scaler_props #(.COUNT_W(COUNT_W)) u_csc_scaler_props (
	.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.sig_a_i(sig_a_i), .sig_b_i(sig_b_i), .display_count_o(display_count_o));

`default_nettype wire

//--- tb/csc_scaler_tb.sv
// Purpose: Self-checking bench for the count input scaler
// Assumes: ce_i held high except during the clock-enable-low check
// Notes:   Expected counts from edges times factor times weight
`timescale 1ns/1ps
`default_nettype none

module csc_scaler_tb;
	logic               ref_clk_i;
	logic               reset_i;
	logic               ce_i;
	logic               wr_i;
	logic               rd_i;
	logic [3:0]         addr_i;
	logic [31:0]        wdata_i;
	logic [31:0]        rdata_o;
	logic               sig_a_i;
	logic               sig_b_i;
	logic signed [31:0] display_count_o;
	int                 fail_count;
	int                 n_compared;
	int                 seed;
	int                 sf;
	int                 n;
	longint             edges;
	int                 wt [4] = '{1000, 100, 10, 1};

	initial ref_clk_i = 1'b0;
	always #2.5 ref_clk_i = ~ref_clk_i;

	csc_scaler #(.COUNT_W(32)) u_csc_scaler (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.sig_a_i(sig_a_i), .sig_b_i(sig_b_i), .display_count_o(display_count_o));

	csc_sensor_model u_csc_sensor_model (.clk_i(ref_clk_i), .a_o(sig_a_i), .b_o(sig_b_i));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 cmp(rdata_o, exp);
	endtask : rdc

	task automatic acc(input longint t);
		repeat (8) @(posedge ref_clk_i);
		cmp(display_count_o, 32'(t / 10000000));
		rdc(4'h2, 32'(t / 10000000));
		rdc(4'h3, 32'(t % 10000000));
	endtask : acc

	// Scaled total in 1e-7 display units: edges times factor times multiplier weight
	function automatic longint scaled(input longint e, input int f, input int scale_multiplier);
		return e * f * wt[scale_multiplier - 1];
	endfunction : scaled

	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 71;
		fail_count = 0;
		n_compared = 0;
		reset_i = 1'b1;
		ce_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 4'h0;
		wdata_i = 32'h0000_0000;
		repeat (4) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rdc(4'h0, 32'h0000_0110);
		rdc(4'h1, 32'h0000_2710);
		rdc(4'h9, 32'h0000_0000);
		for (int m = 0; m < 8; m++) begin
			sf = (m == 0) ? 59999 : $unsigned($random(seed)) % 60000;
			n = 1 + $unsigned($random(seed)) % 8;
			wr(4'h4, 32'h0000_0002);
			wr(4'h0, 32'(((m % 4 + 1) << 8) | ((m / 4 + 1) << 4)));
			wr(4'h1, 32'(sf));
			rdc(4'h1, 32'(sf));
			repeat (n) u_csc_sensor_model.pulse(1 + $unsigned($random(seed)) % 3);
			edges = n * (m / 4 + 1);
			acc(scaled(edges, sf, m % 4 + 1));
		end
		wr(4'h1, 32'd60000);
		rdc(4'h1, 32'(sf));
		wr(4'h0, 32'h0000_0510);
		rdc(4'h0, 32'h0000_0420);
		sf = 6250;
		wr(4'h4, 32'h0000_0002);
		wr(4'h0, 32'h0000_0116);
		wr(4'h1, 32'(sf));
		n = 4 * (1 + $unsigned($random(seed)) % 6);
		repeat (n) u_csc_sensor_model.quad(1'b1, 1 + $unsigned($random(seed)) % 3);
		edges = n;
		acc(scaled(edges, sf, 1));
		// Clock enable low: clear, scale write and a pulse must all be lost
		@(posedge ref_clk_i);
		ce_i <= 1'b0;
		wr(4'h4, 32'h0000_0002);
		wr(4'h1, 32'h0000_1388);
		u_csc_sensor_model.pulse(2);
		ce_i <= 1'b1;
		acc(scaled(edges, sf, 1));
		rdc(4'h1, 32'(sf));
		repeat (n) u_csc_sensor_model.quad(1'b0, 1);
		acc(0);
		wr(4'h4, 32'h0000_0001);
		rdc(4'h0, 32'h0000_0110);
		rdc(4'h1, 32'h0000_2710);
		wrap_up();
	end
endmodule : csc_scaler_tb

`default_nettype wire

//--- tb/csc_sensor_model.sv
// Purpose: Pulse and quadrature sensor model
// Assumes: Pins change after a clock edge, at least two cycles apart
// Notes:   A leads B when moving up
`timescale 1ns/1ps
`default_nettype none

module csc_sensor_model (
	// Clock
	input  wire logic clk_i,
	// Sensor pins
	output logic      a_o,
	output logic      b_o
);
	logic [1:0] ph;

	initial begin
		a_o = 1'b0;
		b_o = 1'b0;
		ph = 2'd0;
	end

	// One full pulse on A
	task automatic pulse(input int gap);
		repeat (2) begin
			@(posedge clk_i);
			a_o <= ~a_o;
			repeat (gap) @(posedge clk_i);
		end
	endtask : pulse

	// One quadrature step, one pin at a time
	task automatic quad(input bit up, input int gap);
		ph = up ? ph + 2'd1 : ph - 2'd1;
		@(posedge clk_i);
		a_o <= ph inside {2'd1, 2'd2};
		b_o <= ph inside {2'd2, 2'd3};
		repeat (gap) @(posedge clk_i);
	endtask : quad
endmodule : csc_sensor_model

`default_nettype wire
